// ---- hw/sbst_pkg.sv ----
// Purpose: Shared constants and types for the status byte and scan trigger logic
// Assumes: 50 MHz system clock
// Notes:   Status bit positions, masks, codes and timing counts live here
package sbst_pkg;

  // ----------------------------------------------------------------
  // Status summary byte layout
  // ----------------------------------------------------------------
  localparam int          STB_ERR_BIT    = 2;
  localparam int          STB_MAV_BIT    = 4;
  localparam int          STB_ESB_BIT    = 5;
  localparam int          STB_RQS_BIT    = 6;
  localparam logic [7:0]  STB_RESET      = 8'h00;
  localparam logic [7:0]  SRE_RESET      = 8'h00;
  localparam logic [7:0]  SRE_USED_MASK  = 8'h34;
  localparam logic [7:0]  STB_NO_RQS     = 8'hbf;

  // ----------------------------------------------------------------
  // Output buffer characters and error codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  ASCII_PASS       = 8'h30;
  localparam logic [7:0]  ASCII_FAIL       = 8'h31;
  localparam logic [15:0] ERR_TRIG_IGNORED = 16'hff2d;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          TRIG_PULSE_NS  = 100;
  localparam logic [7:0]  TRIG_PULSE_CYC = 8'((TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Switching modules
  // ----------------------------------------------------------------
  localparam logic [3:0]  MODULE_IDX_ZERO = 4'h0;

  typedef enum logic [2:0] {
    TRIG_IDLE        = 3'b000,
    TRIG_ARMED       = 3'b001,
    TRIG_DELAY       = 3'b010,
    TRIG_OPEN        = 3'b011,
    TRIG_OPEN_DWELL  = 3'b100,
    TRIG_CLOSE       = 3'b101,
    TRIG_CLOSE_DWELL = 3'b110,
    TRIG_PULSE       = 3'b111
  } trig_state_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_PROBE   = 3'b001,
    ST_WAIT    = 3'b010,
    ST_RESTORE = 3'b011,
    ST_DONE    = 3'b100
  } test_state_t;

  typedef struct packed {
    logic       err_queue_not_empty;
    logic       out_queue_not_empty;
    logic [7:0] event_status;
    logic [7:0] event_enable;
  } status_src_t;

  typedef struct packed {
    logic [15:0] delay;
    logic [15:0] open_dwell;
    logic [15:0] close_dwell;
  } trig_timing_t;

  typedef struct packed {
    logic [7:0] list_len;
    logic [7:0] count;
    logic [7:0] ttl_enable;
    logic       scanner;
  } scan_cfg_t;

endpackage

// ---- hw/relay_self_test.sv ----
// Purpose: Walks every controlled switching module through a relay drive check
// Assumes: Probe handshake answered by the relay drive logic outside
// Notes:   Each module is restored right after its own probe
`timescale 1ns/1ps
module relay_self_test
  import sbst_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [3:0] module_count_i,
  input  wire logic       probe_done_i,
  input  wire logic       probe_ok_i,
  output logic            probe_req_o,
  output logic            restore_o,
  output logic [3:0]      module_idx_o,
  output logic            fail_push_o,
  output logic            done_o,
  output logic            pass_o,
  output logic            busy_o
);

  test_state_t state;
  logic        any_fail;

  assign probe_req_o = (state == ST_PROBE);
  assign restore_o   = (state == ST_RESTORE);
  assign busy_o      = (state != ST_IDLE);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE:    if (start_i) state <= (module_count_i == MODULE_IDX_ZERO) ? ST_DONE : ST_PROBE;
        ST_PROBE:   state <= ST_WAIT;
        ST_WAIT:    if (probe_done_i) state <= ST_RESTORE;
        ST_RESTORE: state <= (module_idx_o == module_count_i - 4'h1) ? ST_DONE : ST_PROBE;
        ST_DONE:    state <= ST_IDLE;
        default:    state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || (state == ST_IDLE)) begin
      module_idx_o <= MODULE_IDX_ZERO;
    end else if (state == ST_RESTORE) begin
      module_idx_o <= module_idx_o + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      any_fail    <= 1'b0;
      fail_push_o <= 1'b0;
      done_o      <= 1'b0;
      pass_o      <= 1'b0;
    end else begin
      fail_push_o <= (state == ST_WAIT) && probe_done_i && !probe_ok_i;
      done_o      <= (state == ST_DONE);
      if (state == ST_DONE) begin
        pass_o <= !any_fail;
      end
      if (state == ST_IDLE) begin
        any_fail <= 1'b0;
      end else if ((state == ST_WAIT) && probe_done_i && !probe_ok_i) begin
        any_fail <= 1'b1;
      end
    end
  end

endmodule

// ---- hw/status_byte_and_scan_trigger.sv ----
// Purpose: Status summary byte, request-true interrupt, scan trigger and self test
// Assumes: Command strobes are one-cycle pulses from the command parser
// Notes:   Error and output queues live outside; this block pushes into them
//
// Overview of operation
// - Query returns the 8-bit summary byte
// - Bit 2 set while error queue not empty
// - Bit 4 set while output buffer not empty
// - Bit 5 set when masked event status nonzero
// - Bit 6 set when enabled summary bits nonzero
// - Bit 6 rising raises request-true interrupt
// - Bus status read clears bit 6 after reporting
// - Query leaves bit 6 following masked summary
// - Trigger command equals bus trigger command
// - Initiate arms until scan count traversed
// - Abort returns to idle at once
// - Trigger runs delay, open, close, pulses in order
// - Trigger during sequence ignored, error queued
// - Trigger while idle ignored, error queued
// - Self test checks and restores each module
// - Self test reports ASCII zero or one
// - Only enable bits 2, 4, 5 work
`timescale 1ns/1ps
module status_byte_and_scan_trigger
  import sbst_pkg::*;
(
  input  wire logic          clk_sys_i,
  input  wire logic          rst_i,
  input  wire status_src_t   status_i,
  input  wire logic          sre_wr_i,
  input  wire logic [7:0]    sre_data_i,
  output logic [7:0]         sre_o,
  input  wire logic          stb_query_i,
  output logic [7:0]         stb_query_data_o,
  output logic               stb_query_valid_o,
  input  wire logic          bus_read_stb_i,
  output logic [7:0]         bus_stb_data_o,
  output logic               bus_stb_valid_o,
  output logic               request_true_o,
  input  wire logic          trg_cmd_i,
  input  wire logic          bus_trigger_i,
  input  wire logic          initiate_i,
  input  wire logic          abort_i,
  input  wire trig_timing_t  timing_i,
  input  wire scan_cfg_t     scan_cfg_i,
  output logic               armed_o,
  output logic               seq_busy_o,
  output logic               channel_open_o,
  output logic               channel_close_o,
  output logic [7:0]         channel_idx_o,
  output logic [7:0]         backplane_trigger_line_o,
  output logic               encode_o,
  output logic               err_push_o,
  output logic [15:0]        err_code_o,
  input  wire logic          selftest_i,
  input  wire logic [3:0]    module_count_i,
  output logic               probe_req_o,
  output logic               restore_o,
  output logic [3:0]         module_idx_o,
  input  wire logic          probe_done_i,
  input  wire logic          probe_ok_i,
  output logic               selftest_fail_push_o,
  output logic               out_push_o,
  output logic [7:0]         out_char_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic masked_any(input logic [7:0] value, input logic [7:0] mask);
    masked_any = |(value & mask);
  endfunction

  // ----------------------------------------------------------------
  // Status summary
  // ----------------------------------------------------------------
  logic [7:0] summary_low;
  logic       master_summary;
  logic       master_summary_d;
  logic       rqs_latched;
  logic       mss_rise;

  always_comb begin
    summary_low = STB_RESET;
    summary_low[STB_ERR_BIT] = status_i.err_queue_not_empty;
    summary_low[STB_MAV_BIT] = status_i.out_queue_not_empty;
    summary_low[STB_ESB_BIT] = masked_any(status_i.event_status, status_i.event_enable);
  end

  assign master_summary = masked_any(summary_low & STB_NO_RQS, sre_o);
  assign mss_rise       = master_summary && !master_summary_d;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sre_o <= SRE_RESET;
    end else if (sre_wr_i) begin
      sre_o <= sre_data_i & SRE_USED_MASK;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      master_summary_d <= 1'b0;
      request_true_o   <= 1'b0;
    end else begin
      master_summary_d <= master_summary;
      request_true_o   <= mss_rise;
    end
  end

  // Set wins over a read in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rqs_latched <= 1'b0;
    end else if (mss_rise) begin
      rqs_latched <= 1'b1;
    end else if (bus_read_stb_i) begin
      rqs_latched <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stb_query_data_o  <= STB_RESET;
      stb_query_valid_o <= 1'b0;
      bus_stb_data_o    <= STB_RESET;
      bus_stb_valid_o   <= 1'b0;
    end else begin
      stb_query_valid_o <= stb_query_i;
      bus_stb_valid_o   <= bus_read_stb_i;
      if (stb_query_i) begin
        stb_query_data_o <= summary_low | (8'(master_summary) << STB_RQS_BIT);
      end
      if (bus_read_stb_i) begin
        bus_stb_data_o <= summary_low | (8'(rqs_latched) << STB_RQS_BIT);
      end
    end
  end

  // ----------------------------------------------------------------
  // Scan trigger sequencer
  // ----------------------------------------------------------------
  trig_state_t state;
  logic        trigger_any;
  logic        trig_accept;
  logic [15:0] wait_cnt;
  logic [7:0]  pulse_cnt;
  logic [7:0]  pass_cnt;
  logic        last_channel;
  logic        scan_done;

  assign trigger_any  = trg_cmd_i || bus_trigger_i;
  assign trig_accept  = trigger_any && (state == TRIG_ARMED);
  assign armed_o      = (state != TRIG_IDLE);
  assign seq_busy_o   = armed_o && (state != TRIG_ARMED);
  assign last_channel = (channel_idx_o == scan_cfg_i.list_len - 8'h01);
  // A count of zero never completes
  assign scan_done    = (scan_cfg_i.count != 8'h00) && (pass_cnt == scan_cfg_i.count);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= TRIG_IDLE;
    end else if (abort_i) begin
      state <= TRIG_IDLE;
    end else begin
      unique case (state)
        TRIG_IDLE:        if (initiate_i) state <= TRIG_ARMED;
        TRIG_ARMED:       if (trig_accept) state <= TRIG_DELAY;
        TRIG_DELAY:       if (wait_cnt == 16'h0000) state <= TRIG_OPEN;
        TRIG_OPEN:        state <= TRIG_OPEN_DWELL;
        TRIG_OPEN_DWELL:  if (wait_cnt == 16'h0000) state <= TRIG_CLOSE;
        TRIG_CLOSE:       state <= TRIG_CLOSE_DWELL;
        TRIG_CLOSE_DWELL: if (wait_cnt == 16'h0000) state <= TRIG_PULSE;
        TRIG_PULSE:       if (pulse_cnt == 8'h01) state <= (scan_done ? TRIG_IDLE : TRIG_ARMED);
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wait_cnt <= 16'h0000;
    end else if (trig_accept) begin
      wait_cnt <= timing_i.delay;
    end else if (state == TRIG_OPEN) begin
      wait_cnt <= timing_i.open_dwell;
    end else if (state == TRIG_CLOSE) begin
      wait_cnt <= timing_i.close_dwell;
    end else if (wait_cnt != 16'h0000) begin
      wait_cnt <= wait_cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pulse_cnt <= 8'h00;
    end else if ((state == TRIG_CLOSE_DWELL) && (wait_cnt == 16'h0000)) begin
      pulse_cnt <= TRIG_PULSE_CYC;
    end else if (pulse_cnt != 8'h00) begin
      pulse_cnt <= pulse_cnt - 8'h01;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || ((state == TRIG_IDLE) && initiate_i)) begin
      channel_idx_o <= 8'h00;
      pass_cnt      <= 8'h00;
    end else if (state == TRIG_CLOSE) begin
      channel_idx_o <= last_channel ? 8'h00 : channel_idx_o + 8'h01;
      if (last_channel) begin
        pass_cnt <= pass_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      channel_open_o           <= 1'b0;
      channel_close_o          <= 1'b0;
      backplane_trigger_line_o <= 8'h00;
      encode_o                 <= 1'b0;
    end else begin
      channel_open_o           <= (state == TRIG_OPEN) && !abort_i;
      channel_close_o          <= (state == TRIG_CLOSE) && !abort_i;
      backplane_trigger_line_o <= (state == TRIG_PULSE) && !abort_i ? scan_cfg_i.ttl_enable : 8'h00;
      encode_o                 <= (state == TRIG_PULSE) && !abort_i && scan_cfg_i.scanner;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      err_push_o <= 1'b0;
      err_code_o <= 16'h0000;
    end else begin
      err_push_o <= trigger_any && !trig_accept;
      if (trigger_any && !trig_accept) begin
        err_code_o <= ERR_TRIG_IGNORED;
      end
    end
  end

  // ----------------------------------------------------------------
  // Self test
  // ----------------------------------------------------------------
  logic test_done;
  logic test_pass;
  logic test_busy;

  relay_self_test u_self_test (
    .clk_sys_i      (clk_sys_i),
    .rst_i          (rst_i),
    .start_i        (selftest_i && !test_busy),
    .module_count_i (module_count_i),
    .probe_done_i   (probe_done_i),
    .probe_ok_i     (probe_ok_i),
    .probe_req_o    (probe_req_o),
    .restore_o      (restore_o),
    .module_idx_o   (module_idx_o),
    .fail_push_o    (selftest_fail_push_o),
    .done_o         (test_done),
    .pass_o         (test_pass),
    .busy_o         (test_busy)
  );

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      out_push_o <= 1'b0;
      out_char_o <= ASCII_PASS;
    end else begin
      out_push_o <= test_done;
      if (test_done) begin
        out_char_o <= test_pass ? ASCII_PASS : ASCII_FAIL;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  chk_query_unused_zero: assert property (
    stb_query_valid_o |-> (stb_query_data_o & 8'h8b) == 8'h00)
    else $error("unused status bits read nonzero");

  chk_query_bits: assert property (
    stb_query_i |=> stb_query_data_o[STB_ERR_BIT] == $past(status_i.err_queue_not_empty))
    else $error("query bit 2 wrong");

  chk_query_mav: assert property (
    stb_query_i |=> stb_query_data_o[STB_MAV_BIT] == $past(status_i.out_queue_not_empty))
    else $error("query bit 4 wrong");

  chk_query_esb: assert property (
    stb_query_i |=> stb_query_data_o[STB_ESB_BIT] == $past(|(status_i.event_status & status_i.event_enable)))
    else $error("query bit 5 wrong");

  chk_query_mss: assert property (
    stb_query_i |=> stb_query_data_o[STB_RQS_BIT] == $past(|(summary_low & sre_o)))
    else $error("query bit 6 wrong");

  chk_sre_unused: assert property (
    (sre_o & 8'hcb) == 8'h00)
    else $error("unused enable bit stored");

  chk_irq_on_rise: assert property (
    $rose(master_summary) |=> request_true_o)
    else $error("no interrupt on summary rise");

  chk_read_destructive: assert property (
    bus_read_stb_i && !mss_rise |=> !rqs_latched)
    else $error("bus read did not clear bit 6");

  chk_abort_idle: assert property (
    abort_i |=> state == TRIG_IDLE)
    else $error("abort did not return to idle");

  chk_ignored_error: assert property (
    trigger_any && seq_busy_o |=> err_push_o && err_code_o == 16'hff2d)
    else $error("busy trigger not reported");

  chk_idle_error: assert property (
    trigger_any && state == TRIG_IDLE |=> err_push_o)
    else $error("idle trigger not reported");

  chk_open_then_close: assert property (
    channel_open_o |-> !channel_close_o && backplane_trigger_line_o == 8'h00)
    else $error("sequence steps overlap");

  chk_selftest_char: assert property (
    out_push_o |-> out_char_o == ASCII_PASS || out_char_o == ASCII_FAIL)
    else $error("self test char wrong");

  cov_trigger_run: cover property (trig_accept ##[1:1000] channel_close_o);
  cov_ignored: cover property (trigger_any && seq_busy_o);
  cov_irq: cover property (request_true_o);
  cov_selftest_fail: cover property (out_push_o && out_char_o == ASCII_FAIL);

endmodule

// ---- verif/relay_drive_model.sv ----
// Purpose: Relay drive responder answering self-test probes
// Assumes: One probe outstanding at a time
// Notes:   Latency alternates prompt and slow; one module index may fail
`timescale 1ns/1ps
module relay_drive_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       probe_req_i,
  input  wire logic [3:0] module_idx_i,
  input  wire logic [4:0] fail_idx_i,
  output logic            probe_done_o,
  output logic            probe_ok_o
);
  logic       pending;
  logic       slow;
  logic [2:0] left;
  logic       ok_hold;

  // ----------------------------------------------------------------
  // Probe answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    probe_done_o <= 1'b0;
    probe_ok_o   <= ~probe_ok_o;
    if (rst_i) begin
      pending    <= 1'b0;
      slow       <= 1'b0;
      left       <= 3'h0;
      probe_ok_o <= 1'b0;
    end else if (probe_req_i) begin
      pending <= 1'b1;
      left    <= slow ? 3'h4 : 3'h0;
      slow    <= ~slow;
      ok_hold <= ({1'b0, module_idx_i} != fail_idx_i);
    end else if (pending && left != 3'h0) begin
      left <= left - 3'h1;
    end else if (pending) begin
      pending      <= 1'b0;
      probe_done_o <= 1'b1;
      probe_ok_o   <= ok_hold;
    end
  end
endmodule

// ---- verif/status_byte_and_scan_trigger_bench.sv ----
// Purpose: Self-checking bench for status byte, scan trigger and self test
// Assumes: Command strobes are single-cycle pulses
// Notes:   Expected values come from a small integer model in the bench
`timescale 1ns/1ps
module status_byte_and_scan_trigger_bench;
  import sbst_pkg::*;
  logic clk_sys_i, rst_i, sre_wr_i, stb_query_i, bus_read_stb_i, trg_cmd_i, bus_trigger_i;
  logic initiate_i, abort_i, selftest_i, probe_done_i, probe_ok_i;
  status_src_t  status_i;
  trig_timing_t timing_i;
  scan_cfg_t    scan_cfg_i;
  logic [7:0]   sre_data_i, sre_o, stb_query_data_o, bus_stb_data_o, channel_idx_o, bp_o, out_char_o;
  logic         stb_query_valid_o, bus_stb_valid_o, request_true_o, armed_o, seq_busy_o, open_o, close_o;
  logic         encode_o, err_push_o, probe_req_o, restore_o, fail_push_o, out_push_o;
  logic [15:0]  err_code_o;
  logic [3:0]   module_count_i, module_idx_o;
  logic [4:0]   fail_idx;
  int err_total, cmp_count, cyc, t_take, q_cnt, b_cnt, rt_cnt, er_cnt, bp_cnt, fl_cnt, rs_cnt, out_cnt, pr_cnt;
  int open_t, close_t, bp_t, sre_m, t_trig, rt0;
  logic [7:0]  q_val, b_val, bp_val, out_val, s;
  logic [15:0] er_code;
  logic        bp_on, enc;
  integer      seed = 32'h08ff;

  status_byte_and_scan_trigger i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .status_i(status_i),
    .sre_wr_i(sre_wr_i), .sre_data_i(sre_data_i), .sre_o(sre_o), .stb_query_i(stb_query_i),
    .stb_query_data_o(stb_query_data_o), .stb_query_valid_o(stb_query_valid_o),
    .bus_read_stb_i(bus_read_stb_i), .bus_stb_data_o(bus_stb_data_o), .bus_stb_valid_o(bus_stb_valid_o),
    .request_true_o(request_true_o), .trg_cmd_i(trg_cmd_i), .bus_trigger_i(bus_trigger_i),
    .initiate_i(initiate_i), .abort_i(abort_i), .timing_i(timing_i), .scan_cfg_i(scan_cfg_i),
    .armed_o(armed_o), .seq_busy_o(seq_busy_o), .channel_open_o(open_o), .channel_close_o(close_o),
    .channel_idx_o(channel_idx_o), .backplane_trigger_line_o(bp_o), .encode_o(encode_o),
    .err_push_o(err_push_o), .err_code_o(err_code_o), .selftest_i(selftest_i),
    .module_count_i(module_count_i), .probe_req_o(probe_req_o), .restore_o(restore_o),
    .module_idx_o(module_idx_o), .probe_done_i(probe_done_i), .probe_ok_i(probe_ok_i),
    .selftest_fail_push_o(fail_push_o), .out_push_o(out_push_o), .out_char_o(out_char_o));

  relay_drive_model i_relay (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .probe_req_i(probe_req_o),
    .module_idx_i(module_idx_o), .fail_idx_i(fail_idx), .probe_done_o(probe_done_i), .probe_ok_o(probe_ok_i));

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task chk_v(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h seen %h", n, e, g);
    end
  endtask
  task chk_n(input string n, input int e, input int g);
    cmp_count++;
    if (g != e) begin
      err_total++;
      $display("BAD %s exp %0d seen %0d", n, e, g);
    end
  endtask
  task end_of_test;
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_for(ref int c, input int tgt);
    int n;
    n = 0;
    while (c < tgt && n < 400) begin
      @(posedge clk_sys_i);
      n++;
    end
    #1;
    if (c < tgt) begin
      chk_n("wait", tgt, c);
      end_of_test;
    end
  endtask

  // ----------------------------------------------------------------
  // Stimulus helpers and model
  // ----------------------------------------------------------------
  task pulse(input int k);
    @(posedge clk_sys_i);
    stb_query_i <= (k == 0); bus_read_stb_i <= (k == 1); trg_cmd_i <= (k == 2); bus_trigger_i <= (k == 3);
    initiate_i <= (k == 4); abort_i <= (k == 5); selftest_i <= (k == 6); sre_wr_i <= (k == 7);
    @(posedge clk_sys_i);
    t_take = cyc;
    {stb_query_i, bus_read_stb_i, trg_cmd_i, bus_trigger_i, initiate_i, abort_i, selftest_i, sre_wr_i} <= 8'h00;
    #1;
  endtask
  task set_sre(input logic [7:0] d);
    @(posedge clk_sys_i);
    sre_data_i <= d;
    sre_m = d & 8'h34;
    pulse(7);
  endtask
  task query(input logic [7:0] e);
    int q0;
    q0 = q_cnt;
    pulse(0);
    wait_for(q_cnt, q0 + 1);
    chk_v("query", e, q_val);
  endtask
  task bus_read(input logic [7:0] e);
    int b0;
    b0 = b_cnt;
    pulse(1);
    wait_for(b_cnt, b0 + 1);
    chk_v("bus_read", e, b_val);
  endtask
  task trig_err(input int k);
    int e0;
    e0 = er_cnt;
    pulse(k);
    wait_for(er_cnt, e0 + 1);
    chk_v("err_code", 16'hff2d, er_code);
  endtask
  function automatic logic [7:0] summ();
    summ = {2'b00, |(status_i.event_status & status_i.event_enable), status_i.out_queue_not_empty,
            1'b0, status_i.err_queue_not_empty, 2'b00};
  endfunction

  // ----------------------------------------------------------------
  // Output monitor
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (stb_query_valid_o) begin q_cnt <= q_cnt + 1; q_val <= stb_query_data_o; end
    if (bus_stb_valid_o) begin b_cnt <= b_cnt + 1; b_val <= bus_stb_data_o; end
    if (request_true_o) rt_cnt <= rt_cnt + 1;
    if (err_push_o) begin er_cnt <= er_cnt + 1; er_code <= err_code_o; end
    if (open_o) open_t <= cyc;
    if (close_o) close_t <= cyc;
    if (bp_o != 8'h00 && !bp_on) begin bp_cnt <= bp_cnt + 1; bp_t <= cyc; bp_val <= bp_o; end
    bp_on <= (bp_o != 8'h00);
    enc <= enc | encode_o;
    if (fail_push_o) fl_cnt <= fl_cnt + 1;
    if (restore_o) rs_cnt <= rs_cnt + 1;
    if (out_push_o) begin out_cnt <= out_cnt + 1; out_val <= out_char_o; end
    if (probe_req_o) begin
      chk_v("probe_idx", 16'(pr_cnt), 16'(module_idx_o));
      pr_cnt <= pr_cnt + 1;
    end
  end

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    {stb_query_i, bus_read_stb_i, trg_cmd_i, bus_trigger_i, initiate_i, abort_i, selftest_i, sre_wr_i} = 8'h00;
    status_i = '0; sre_data_i = 8'h00; module_count_i = 4'h3; fail_idx = 5'h1f;
    timing_i = {16'h0002, 16'h0003, 16'h0001};
    scan_cfg_i = {8'h02, 8'h01, 8'h05, 1'b1};
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk_v("out_char_rst", 16'h0030, 16'(out_char_o));
    chk_v("armed_rst", 16'h0000, 16'(armed_o));
    set_sre(8'hff);
    chk_v("sre", 16'h0034, 16'(sre_o));
    // Random status sources against the summary model
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys_i);
      status_i <= 18'($random(seed));
      set_sre(8'($random(seed)));
      s = summ();
      query(s | (((s & 8'(sre_m)) != 8'h00) ? 8'h40 : 8'h00));
    end
    // Mid-run reset, then destructive bus read against the live query
    @(posedge clk_sys_i);
    rst_i    <= 1'b1;
    status_i <= '0;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    set_sre(8'h10);
    repeat (3) @(posedge clk_sys_i);
    bus_read(8'h00);
    rt0 = rt_cnt;
    @(posedge clk_sys_i);
    status_i.out_queue_not_empty <= 1'b1;
    wait_for(rt_cnt, rt0 + 1);
    bus_read(8'h50);
    bus_read(8'h10);
    query(8'h50);
    query(8'h50);
    set_sre(8'h00);
    query(8'h10);
    // Scan trigger
    trig_err(2);
    pulse(4);
    chk_v("armed", 16'h0001, 16'(armed_o));
    pulse(2);
    t_trig = t_take;
    trig_err(3);
    chk_v("seq_busy", 16'h0001, 16'(seq_busy_o));
    wait_for(bp_cnt, 1);
    chk_n("open_delay", 2 + 3, open_t - t_trig);
    chk_n("open_to_close", 3 + 2, close_t - open_t);
    chk_n("close_to_pulse", 1 + 2, bp_t - close_t);
    chk_v("bp_lines", 16'h0005, 16'(bp_val));
    chk_v("encode", 16'h0001, 16'(enc));
    chk_v("chan_idx", 16'h0001, 16'(channel_idx_o));
    repeat (8) @(posedge clk_sys_i);
    pulse(3);
    wait_for(bp_cnt, 2);
    repeat (8) @(posedge clk_sys_i);
    #1;
    chk_v("armed_end", 16'h0000, 16'(armed_o));
    trig_err(2);
    pulse(4);
    pulse(2);
    repeat (2) @(posedge clk_sys_i);
    pulse(5);
    chk_v("abort", 16'h0000, 16'(armed_o));
    repeat (20) @(posedge clk_sys_i);
    chk_n("abort_pulses", 2, bp_cnt);
    // Self test, one failing module then all passing
    fail_idx <= 5'h01;
    pulse(6);
    wait_for(out_cnt, 1);
    chk_n("restores", 3, rs_cnt);
    chk_n("fails", 1, fl_cnt);
    chk_v("result", 16'h0031, 16'(out_val));
    fail_idx <= 5'h1f;
    pr_cnt = 0;
    pulse(6);
    wait_for(out_cnt, 2);
    chk_n("restores2", 6, rs_cnt);
    chk_n("fails2", 1, fl_cnt);
    chk_v("result2", 16'h0030, 16'(out_val));
    end_of_test;
  end
endmodule
